/* File: inc/timer_two_defines.vh */
`ifndef TIMER_TWO_DEFINES_VH
`define TIMER_TWO_DEFINES_VH
// special function register addresses
`define T2_ADDR_CONTROL 8'hc8
`define T2_ADDR_RELOAD_LOW 8'hca
`define T2_ADDR_RELOAD_HIGH 8'hcb
`define T2_ADDR_COUNT_LOW 8'hcc
`define T2_ADDR_COUNT_HIGH 8'hcd
// control register field positions
`define T2_BIT_HIGH_FLAG 7
`define T2_BIT_LOW_FLAG 6
`define T2_BIT_LOW_IRQ_EN 5
`define T2_BIT_CAPTURE_EN 4
`define T2_BIT_SPLIT 3
`define T2_BIT_RUN 2
`define T2_BIT_ALT_SEL_HI 1
`define T2_BIT_ALT_SEL_LO 0
// reset values
`define T2_CONTROL_RESET 8'h00
`define T2_BYTE_RESET 8'h00
// alternate clock select encodings
`define T2_SEL_DIV12_TRIG_RTC 2'h0
`define T2_SEL_CMP_TRIG_RTC 2'h1
`define T2_SEL_DIV12_TRIG_CMP 2'h2
`define T2_SEL_RTC_TRIG_CMP 2'h3
// timing counts
`define T2_SYSCLK_DIVIDE 12
`define T2_RTC_DIVIDE 8
`endif

/* File: hw/tick_divider.v */
`timescale 1ns/100ps
// one-cycle pulse every DIVIDE input events
module tick_divider #(
   parameter DIVIDE = 12
) (
   input wire clk, // system clock
   input wire rst_n, // asynchronous reset, active low
   input wire event_in, // one-cycle event to count
   output reg tick_out // pulse on every DIVIDE-th event
);
   localparam integer CW = 8;
   localparam integer LAST_INT = DIVIDE - 1;
   // cut on purpose: DIVIDE never exceeds the counter's range
   localparam [CW-1:0] LAST = LAST_INT[CW-1:0];
   reg [CW-1:0] count_reg;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= {CW{1'b0}};
         tick_out <= 1'b0;
      end else begin
         tick_out <= 1'b0;
         if (event_in) begin
            if (count_reg == LAST) begin
               count_reg <= {CW{1'b0}};
               tick_out <= 1'b1;
            end else begin
               count_reg <= count_reg + 8'h01;
            end
         end
      end
   end
endmodule // tick_divider

/* File: hw/edge_sync.v */
`timescale 1ns/100ps
// two-flop synchroniser plus rising edge detect on the second stage
module edge_sync (
   input wire clk, // system clock
   input wire rst_n, // asynchronous reset, active low
   input wire async_in, // level from another clock domain
   output reg rise_out // one-cycle pulse on a synchronised rising edge
);
   reg meta_reg;
   reg sync_reg;
   reg last_reg;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
         rise_out <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
         rise_out <= sync_reg & ~last_reg;
      end
   end
endmodule // edge_sync

/* File: hw/timer_two.v */
`timescale 1ns/100ps
`include "timer_two_defines.vh"
// How it works
// R1: high overflow flag sets when the high byte wraps, full counter in 16-bit mode.
// R2: with timer interrupt enabled, a high flag set raises an interrupt request.
// R3: flags are never cleared by hardware; software writes zero to clear.
// R4: low overflow flag sets on every low byte wrap, in either mode.
// R5: low byte interrupt enable plus timer enable requests interrupt on low wraps.
// R6: capture enable bit set puts the timer into capture mode.
// R7: split bit gives two 8-bit reload timers, else one 16-bit timer.
// R8: run bit enables counting; cleared in 16-bit mode stops the whole timer.
// R9: in split mode run gates only the high byte; low byte always counts.
// R10: two-bit select chooses alternate clock and capture trigger, shared by bytes.
// R11: per-byte choice bits pick alternate clock or the system clock.
// R12: alternate clock sources are synchronised before advancing the counter.
// R13: select decodes 00 div12/rtc8, 01 cmp/rtc8, 10 div12/cmp, 11 rtc8/cmp.
// R14: control register at 0xc8 is bit-addressable; bit writes touch one field.
// R15: 16-bit wrap loads the 16-bit reload value into the counter.
// R16: in split mode each byte reloads from its own reload byte.
// R17: each capture trigger copies the counter to reload and sets high flag.
// R18: the low byte, and in split mode the high byte, increments by one per tick of its selected clock.
module timer_two (
   input wire clk, // system clock, 25 MHz
   input wire rst_n, // asynchronous reset, active low
   input wire [7:0] sfr_addr, // special function register address
   input wire sfr_wr, // byte write strobe
   input wire [7:0] sfr_wdata, // byte write data
   input wire sfr_bit_wr, // single-bit write strobe
   input wire [2:0] sfr_bit_sel, // bit position for bit write
   input wire sfr_bit_val, // value for bit write
   output reg [7:0] sfr_rdata, // read data for sfr_addr
   input wire high_byte_clock_choice, // 1: high byte uses system clock
   input wire low_byte_clock_choice, // 1: low byte uses system clock
   input wire rtc_clock_in, // real-time clock, asynchronous
   input wire comparator_in, // comparator 0 output, asynchronous
   input wire timer_irq_enable, // timer interrupt enable from the core
   output wire timer_irq, // interrupt request level
   output wire capture_mode, // capture mode active
   output wire split_mode, // split mode active
   output wire [7:0] count_low_byte, // low counter byte
   output wire [7:0] count_high_byte // high counter byte
);
   reg [7:0] timer_two_control;
   reg [7:0] count_low_reg;
   reg [7:0] count_high_reg;
   reg [7:0] reload_low_reg;
   reg [7:0] reload_high_reg;
   reg div12_tick;
   reg [3:0] div12_reg;
   wire rtc_rise;
   wire cmp_rise;
   wire rtc8_tick;
   reg alt_tick;
   reg trigger;
   wire low_tick;
   wire high_tick;
   wire low_run;
   wire high_run;
   wire low_wrap;
   wire high_wrap;
   wire capture_evt;
   reg [7:0] ctrl_next;

   function [7:0] bit_merge;
      input [7:0] old;
      input [2:0] sel;
      input val;
      begin
         bit_merge = old;
         bit_merge[sel] = val;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // clock sources

   // free-running system clock divide by 12
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div12_reg <= 4'h0;
         div12_tick <= 1'b0;
      end else begin
         div12_tick <= 1'b0;
         if (div12_reg == 4'hb) begin
            div12_reg <= 4'h0;
            div12_tick <= 1'b1;
         end else begin
            div12_reg <= div12_reg + 4'h1;
         end
      end
   end

   edge_sync rtc_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(rtc_clock_in),
      .rise_out(rtc_rise)
   ); // R12

   edge_sync cmp_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(comparator_in),
      .rise_out(cmp_rise)
   ); // R12

   tick_divider #(
      .DIVIDE(`T2_RTC_DIVIDE)
   ) rtc_div (
      .clk(clk),
      .rst_n(rst_n),
      .event_in(rtc_rise),
      .tick_out(rtc8_tick)
   );

   // one select field drives both bytes' alternate clock and the trigger
   always @* begin
      case (timer_two_control[`T2_BIT_ALT_SEL_HI:`T2_BIT_ALT_SEL_LO]) // R10 R13
         `T2_SEL_DIV12_TRIG_RTC: begin
            alt_tick = div12_tick;
            trigger = rtc8_tick;
         end
         `T2_SEL_CMP_TRIG_RTC: begin
            alt_tick = cmp_rise;
            trigger = rtc8_tick;
         end
         `T2_SEL_DIV12_TRIG_CMP: begin
            alt_tick = div12_tick;
            trigger = cmp_rise;
         end
         default: begin
            alt_tick = rtc8_tick;
            trigger = cmp_rise;
         end
      endcase
   end

   assign low_tick = low_byte_clock_choice ? 1'b1 : alt_tick; // R11
   assign high_tick = high_byte_clock_choice ? 1'b1 : alt_tick; // R11

   ////////////////////////////////////////////////////////////////////////
   // counting

   assign split_mode = timer_two_control[`T2_BIT_SPLIT]; // R7
   assign capture_mode = timer_two_control[`T2_BIT_CAPTURE_EN]; // R6
   // low byte free-runs in split mode; in 16-bit mode both halves obey run
   assign low_run = split_mode | timer_two_control[`T2_BIT_RUN]; // R8 R9
   assign high_run = timer_two_control[`T2_BIT_RUN]; // R8 R9

   // in 16-bit mode the high byte steps on low carry, using the low clock
   assign low_wrap = low_run & low_tick & (count_low_reg == 8'hff); // R4
   assign high_wrap = split_mode ?
      (high_run & high_tick & (count_high_reg == 8'hff)) :
      (low_wrap & (count_high_reg == 8'hff)); // R1
   assign capture_evt = capture_mode & trigger; // R17

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_low_reg <= `T2_BYTE_RESET;
         count_high_reg <= `T2_BYTE_RESET;
         reload_low_reg <= `T2_BYTE_RESET;
         reload_high_reg <= `T2_BYTE_RESET;
      end else begin
         // low byte
         if (sfr_wr && sfr_addr == `T2_ADDR_COUNT_LOW) begin
            count_low_reg <= sfr_wdata;
         end else if (low_wrap) begin
            // 16-bit wrap reloads low only when the high byte also wraps
            if (split_mode || high_wrap) begin
               count_low_reg <= reload_low_reg; // R15 R16
            end else begin
               count_low_reg <= 8'h00;
            end
         end else if (low_run && low_tick) begin
            count_low_reg <= count_low_reg + 8'h01; // R18
         end
         // high byte
         if (sfr_wr && sfr_addr == `T2_ADDR_COUNT_HIGH) begin
            count_high_reg <= sfr_wdata;
         end else if (high_wrap) begin
            count_high_reg <= reload_high_reg; // R15 R16
         end else if (split_mode ? (high_run && high_tick) : low_wrap) begin
            count_high_reg <= count_high_reg + 8'h01; // R18
         end
         // reload registers; capture overrides a same-cycle software write
         if (capture_evt) begin
            reload_low_reg <= count_low_reg; // R17
            reload_high_reg <= count_high_reg; // R17
         end else begin
            if (sfr_wr && sfr_addr == `T2_ADDR_RELOAD_LOW) begin
               reload_low_reg <= sfr_wdata;
            end
            if (sfr_wr && sfr_addr == `T2_ADDR_RELOAD_HIGH) begin
               reload_high_reg <= sfr_wdata;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control register

   always @* begin
      ctrl_next = timer_two_control;
      if (sfr_wr && sfr_addr == `T2_ADDR_CONTROL) begin
         ctrl_next = sfr_wdata;
      end else if (sfr_bit_wr && sfr_addr == `T2_ADDR_CONTROL) begin
         ctrl_next = bit_merge(timer_two_control, sfr_bit_sel, sfr_bit_val); // R14
      end
      // hardware sets win over a same-cycle software clear
      if (high_wrap || capture_evt) begin
         ctrl_next[`T2_BIT_HIGH_FLAG] = 1'b1; // R1 R17
      end
      if (low_wrap) begin
         ctrl_next[`T2_BIT_LOW_FLAG] = 1'b1; // R4
      end
   end

   // flags only ever clear through the software write paths above
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_two_control <= `T2_CONTROL_RESET;
      end else begin
         timer_two_control <= ctrl_next; // R3
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt and read path

   // level request: stays up until software clears the causing flag
   assign timer_irq = timer_irq_enable & (timer_two_control[`T2_BIT_HIGH_FLAG] |
      (timer_two_control[`T2_BIT_LOW_IRQ_EN] & timer_two_control[`T2_BIT_LOW_FLAG])); // R2 R5

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
      end else begin
         case (sfr_addr)
            `T2_ADDR_CONTROL: sfr_rdata <= ctrl_next;
            `T2_ADDR_RELOAD_LOW: sfr_rdata <= reload_low_reg;
            `T2_ADDR_RELOAD_HIGH: sfr_rdata <= reload_high_reg;
            `T2_ADDR_COUNT_LOW: sfr_rdata <= count_low_reg;
            `T2_ADDR_COUNT_HIGH: sfr_rdata <= count_high_reg;
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   assign count_low_byte = count_low_reg;
   assign count_high_byte = count_high_reg;
endmodule // timer_two

/* File: tb/timer_two_chk.sv */
`timescale 1ns/100ps
module timer_two_chk (
   input wire logic clk, // clock
   input wire logic rst_n, // reset
   input wire logic [7:0] sfr_addr, // address
   input wire logic sfr_wr, // byte write
   input wire logic [7:0] sfr_wdata, // data
   input wire logic sfr_bit_wr, // bit write
   input wire logic [2:0] sfr_bit_sel, // bit number
   input wire logic sfr_bit_val, // bit value
   input wire logic low_byte_clock_choice, // low clock
   input wire logic timer_irq_enable, // irq enable
   input wire logic timer_irq, // irq
   input wire logic capture_mode, // capture
   input wire logic split_mode, // split
   input wire logic [7:0] count_low_byte, // low count
   input wire logic [7:0] count_high_byte // high count
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
//////////////////////////////////////////
// shadow of two control bits that no port shows, low irq enable and run
logic len_reg;
logic run_reg;
wire ctl_wr = sfr_wr && sfr_addr == 8'hc8;
wire ctl_bit = sfr_bit_wr && sfr_addr == 8'hc8;
always @(posedge clk or negedge rst_n) begin
   if (!rst_n) begin
      len_reg <= 1'b0;
      run_reg <= 1'b0;
   end else if (ctl_wr) begin
      len_reg <= sfr_wdata[5];
      run_reg <= sfr_wdata[2];
   end else if (ctl_bit) begin
      if (sfr_bit_sel == 3'h5) len_reg <= sfr_bit_val;
      if (sfr_bit_sel == 3'h2) run_reg <= sfr_bit_val;
   end
end
sequence s_low_top;
   count_low_byte == 8'hff && !sfr_wr && low_byte_clock_choice && (split_mode || run_reg);
endsequence
sequence s_full_top;
   s_low_top ##0 (count_high_byte == 8'hff && !split_mode);
endsequence
//////////////////////////////////////////
a_split_follow: assert property (ctl_wr |=> split_mode == $past(sfr_wdata[3]))
   else $error("split mode not taken from write");
a_capture_follow: assert property (ctl_wr |=> capture_mode == $past(sfr_wdata[4]))
   else $error("capture mode not taken from write");
a_bit_write: assert property (ctl_bit && !sfr_wr && sfr_bit_sel == 3'h3 |=>
   split_mode == $past(sfr_bit_val) && $stable(capture_mode)) else $error("bit write wrong");
a_irq_gate: assert property (!timer_irq_enable |-> !timer_irq)
   else $error("irq without enable");
a_flag_sticky: assert property (timer_irq && !sfr_wr && !sfr_bit_wr ##1 timer_irq_enable
   |-> timer_irq) else $error("flag dropped by itself");
a_low_wrap_irq: assert property (s_low_top ##1 (len_reg && timer_irq_enable) |-> timer_irq)
   else $error("no irq on low wrap");
a_high_wrap_irq: assert property (s_full_top ##1 timer_irq_enable |-> timer_irq)
   else $error("no irq on full wrap");
a_count_step: assert property (!sfr_wr && low_byte_clock_choice && (split_mode || run_reg)
   && count_low_byte != 8'hff |=> count_low_byte == $past(count_low_byte) + 8'h01)
   else $error("low byte did not step");
a_run_stop: assert property (!run_reg && !split_mode && !sfr_wr |=>
   $stable(count_low_byte) && $stable(count_high_byte)) else $error("count moved while stopped");
endmodule // timer_two_chk

/* File: tb/timer_two_tb.sv */
`timescale 1ns/100ps
module timer_two_tb;
logic clk, rst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, hi_ch, lo_ch, rtc, cmp, irq_en;
logic rd_flag, rd_d;
logic [7:0] sfr_addr, sfr_wdata, rl, rh, v0, v1;
logic [2:0] sfr_bit_sel;
logic [7:0] exp_q[$];
wire [7:0] sfr_rdata;
wire timer_irq;
integer bad_count, samples_checked, seed, i;
timer_two u_timer_two (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
   .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
   .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata), .high_byte_clock_choice(hi_ch),
   .low_byte_clock_choice(lo_ch), .rtc_clock_in(rtc), .comparator_in(cmp),
   .timer_irq_enable(irq_en), .timer_irq(timer_irq), .capture_mode(), .split_mode(),
   .count_low_byte(), .count_high_byte());
initial begin
   clk = 1'b0;
   forever #20 clk = ~clk;
end
//////////////////////////////////////////
task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
   samples_checked = samples_checked + 1;
   if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("Error %s expected %h seen %h", nm, exp, seen);
   end
endtask
task wr(input logic [7:0] a, input logic [7:0] d);
   @(negedge clk);
   sfr_addr = a;
   sfr_wdata = d;
   sfr_wr = 1'b1;
   @(negedge clk);
   sfr_wr = 1'b0;
endtask
task bw(input logic [2:0] s, input logic v);
   @(negedge clk);
   sfr_addr = 8'hc8;
   sfr_bit_sel = s;
   sfr_bit_val = v;
   sfr_bit_wr = 1'b1;
   @(negedge clk);
   sfr_bit_wr = 1'b0;
endtask
// a read only notes what it expects; the monitor compares once data lands
task rd(input logic [7:0] a, input logic [7:0] e);
   @(negedge clk);
   sfr_addr = a;
   exp_q.push_back(e);
   rd_flag = 1'b1;
   @(negedge clk);
   rd_flag = 1'b0;
endtask
always @(posedge clk) begin
   rd_d <= rd_flag;
   if (rd_d === 1'b1) chk("rdata", sfr_rdata, exp_q.pop_front());
end
task end_of_test;
   $display("checked %0d mismatches %0d", samples_checked, bad_count);
   if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
   end else begin
      $display("SIMULATION FAILED");
   end
   $finish;
endtask
initial begin
   #200000;
   bad_count = bad_count + 1;
   end_of_test;
end
//////////////////////////////////////////
initial begin
   seed = 32'hc3dd;
   {bad_count, samples_checked} = 0;
   {rst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, hi_ch, lo_ch, rtc, cmp, irq_en, rd_flag} = 0;
   {sfr_addr, sfr_wdata, sfr_bit_sel} = 0;
   repeat (12) @(posedge clk);
   @(negedge clk) rst_n = 1'b1;
   for (i = 0; i < 6; i++) rd(8'hc8 + i[7:0], 8'h00);
   rl = $random(seed);
   v0 = $random(seed);
   rh = v0 & 8'h7f;
   wr(8'hc9, rl);
   rd(8'hc9, 8'h00);
   $display("test reset done");
   wr(8'hca, rl);
   wr(8'hcb, rh);
   wr(8'hcc, 8'hfe);
   wr(8'hcd, 8'hff);
   lo_ch = 1'b1;
   irq_en = 1'b1;
   wr(8'hc8, 8'h04);
   bw(3'h2, 1'b0);
   rd(8'hcc, rl);
   rd(8'hcd, rh);
   chk("irq", {7'h00, timer_irq}, 8'h01);
   repeat (5) @(negedge clk);
   rd(8'hc8, 8'hc0);
   bw(3'h7, 1'b0);
   bw(3'h6, 1'b0);
   rd(8'hc8, 8'h00);
   chk("irq", {7'h00, timer_irq}, 8'h00);
   $display("test wrap done");
   lo_ch = 1'b0;
   wr(8'hc8, 8'h29);
   wr(8'hcd, 8'hff);
   wr(8'hcc, 8'hfe);
   lo_ch = 1'b1;
   repeat (2) @(negedge clk);
   lo_ch = 1'b0;
   chk("irq", {7'h00, timer_irq}, 8'h01);
   rd(8'hcc, rl);
   rd(8'hcd, 8'hff);
   hi_ch = 1'b1;
   bw(3'h2, 1'b1);
   bw(3'h2, 1'b0);
   rd(8'hcd, rh + 8'h01);
   rd(8'hc8, 8'he9);
   bw(3'h3, 1'b0);
   rd(8'hc8, 8'he1);
   $display("test split done");
   for (i = 0; i < 4; i++) begin
      v0 = $random(seed);
      v1 = $random(seed);
      wr(8'hcc, v0);
      wr(8'hcd, v1);
      wr(8'hc8, 8'h10 | i[7:0]);
      cmp = 1'b1;
      repeat (6) @(negedge clk);
      cmp = 1'b0;
      // eight slow clock rises make one divided trigger, driven only in the select 01 pass
      if (i == 1) begin
         repeat (8) begin
            rtc = 1'b1;
            repeat (2) @(negedge clk);
            rtc = 1'b0;
            repeat (2) @(negedge clk);
         end
      end
      if (i != 0) begin
         rl = v0;
         rh = v1;
      end
      rd(8'hca, rl);
      rd(8'hcb, rh);
      rd(8'hc8, ((i != 0) ? 8'h90 : 8'h10) | i[7:0]);
   end
   $display("test capture done");
   repeat (2) @(negedge clk);
   end_of_test;
end
endmodule // timer_two_tb
bind timer_two timer_two_chk u_timer_two_chk (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
   .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
   .sfr_bit_val(sfr_bit_val), .low_byte_clock_choice(low_byte_clock_choice),
   .timer_irq_enable(timer_irq_enable), .timer_irq(timer_irq), .capture_mode(capture_mode),
   .split_mode(split_mode), .count_low_byte(count_low_byte), .count_high_byte(count_high_byte));
